// *** src/tmi_map.vh ***
// Purpose: constants for the timer interrupt and control block
// Assumes: 8-bit register port, 100 MHz clock
// Notes:   offsets are word indices on the plain register port
`ifndef TMI_MAP_VH
`define TMI_MAP_VH

// register addresses
`define TMI_ADDR_CTRL1       4'h0
`define TMI_ADDR_CTRL2       4'h1
`define TMI_ADDR_STATUS      4'h2
`define TMI_ADDR_IRQ_STAT    4'h3
`define TMI_ADDR_IRQ_CLR     4'h4
`define TMI_ADDR_IRQ_EN      4'h5
`define TMI_ADDR_CMP2_SHADOW 4'h6

// first control register fields
`define TMI_C1_CAP_IE        7
`define TMI_C1_CMP_IE        6
`define TMI_C1_OVF_IE        5
`define TMI_C1_FORCE2        4
`define TMI_C1_FORCE1        3
`define TMI_C1_LVL2          2
`define TMI_C1_EDGE1         1
`define TMI_C1_LVL1          0

// second control register fields
`define TMI_C2_PIN1_EN       7
`define TMI_C2_PIN2_EN       6
`define TMI_C2_SINGLE        5
`define TMI_C2_PWM           4
`define TMI_C2_CLK_HI        3
`define TMI_C2_CLK_LO        2
`define TMI_C2_EDGE2         1
`define TMI_C2_EXT_EDGE      0

// status flag positions
`define TMI_ST_CAP1          7
`define TMI_ST_CMP1          6
`define TMI_ST_OVF           5
`define TMI_ST_CAP2          4
`define TMI_ST_CMP2          3

// clock select codes
`define TMI_CS_DIV4          2'h0
`define TMI_CS_DIV2          2'h1
`define TMI_CS_DIV8          2'h2
`define TMI_CS_EXT           2'h3

// reset values
`define TMI_CTRL1_RST        8'h00
`define TMI_CTRL2_RST        8'h00

`endif

// *** src/tmi_shadow_mem.v ***
// Purpose: holding store for the second compare value bytes, write-only in the first instance
// Assumes: one clock, registered read data
// Notes:   read port feeds the read mux; software reads these back in the second instance only
`timescale 1ns/1ns
`default_nettype none

module tmi_shadow_mem (
   input  wire       i_mclk,
   input  wire       i_rst_n,
   input  wire       i_we,
   input  wire       i_sel,
   input  wire [7:0] i_wdata,
   output reg  [7:0] o_rdata_hi,
   output reg  [7:0] o_rdata_lo
);

   reg [7:0] mem_r [0:1];

   ////////////////////////////////////////////////////////////////////////
   // byte store with registered read out
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_r[0]   <= 8'h00;
         mem_r[1]   <= 8'h00;
         o_rdata_hi <= 8'h00;
         o_rdata_lo <= 8'h00;
      end else begin
         if (i_we) begin
            mem_r[i_sel] <= i_wdata;
         end
         o_rdata_hi <= mem_r[1];
         o_rdata_lo <= mem_r[0];
      end
   end

endmodule

`default_nettype wire

// *** src/tmi_timer_ctrl.v ***
// Purpose: interrupt gating, control registers and compare pin drive
//          of a 16-bit timer
// Assumes: flag events come from the timer datapath on i_mclk;
//          capture pin is asynchronous and is synchronised here
// Notes:   one shared interrupt output, wake request for wait state
`timescale 1ns/1ns
`default_nettype none
`include "tmi_map.vh"

module tmi_timer_ctrl #(
   parameter FIRST_INSTANCE = 1
) (
   input  wire       i_mclk,
   input  wire       i_rst_n,
   input  wire [3:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   input  wire       i_cpu_mask,
   input  wire       i_in_wait,
   input  wire       i_cap1_pin,
   input  wire       i_cap2_evt,
   input  wire       i_cmp1_match,
   input  wire       i_cmp2_match,
   input  wire       i_ovf_evt,
   input  wire       i_flag_clr_cap1,
   input  wire       i_flag_clr_cap2,
   input  wire       i_flag_clr_cmp1,
   input  wire       i_flag_clr_cmp2,
   input  wire       i_flag_clr_ovf,
   output reg  [7:0] o_rdata,
   output reg        o_irq,
   output reg        o_wake,
   output reg        o_cap1_trig,
   output reg        o_tick,
   output reg        o_cmp_pin1,
   output reg        o_cmp_pin1_oe,
   output reg        o_cmp_pin2,
   output reg        o_cmp_pin2_oe
);

   reg  [7:0] ctrl1_r;
   reg  [7:0] ctrl2_r;
   reg  [4:0] flag_r;
   reg  [4:0] evt_stat_r;
   reg  [4:0] evt_en_r;
   reg        cap_s1_r;
   reg        cap_s2_r;
   reg        cap_d_r;
   reg  [2:0] div_r;
   reg  [7:0] rdata_nxt;
   reg  [4:0] flag_set;
   wire [4:0] flag_clr;
   wire       pwm_mode;
   wire       pulse_mode;
   wire       cap1_edge;
   wire       irq_req;
   wire       cap_gate;
   wire       cmp_gate;
   wire       ovf_gate;
   wire       evt_gate;
   wire [7:0] sh_hi;
   wire [7:0] sh_lo;
   wire       sh_we;

   assign pwm_mode   = ctrl2_r[`TMI_C2_PWM];
   assign pulse_mode = pwm_mode | ctrl2_r[`TMI_C2_SINGLE];
   assign flag_clr   = {i_flag_clr_cap1, i_flag_clr_cmp1, i_flag_clr_ovf,
                        i_flag_clr_cap2, i_flag_clr_cmp2};

   ////////////////////////////////////////////////////////////////////////
   // capture pin synchroniser and edge detect
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap_s1_r <= 1'b0;
         cap_s2_r <= 1'b0;
         cap_d_r  <= 1'b0;
      end else begin
         cap_s1_r <= i_cap1_pin;
         cap_s2_r <= cap_s1_r;
         cap_d_r  <= cap_s2_r;
      end
   end

   assign cap1_edge = ctrl1_r[`TMI_C1_EDGE1] ? (cap_s2_r & ~cap_d_r)
                                             : (~cap_s2_r & cap_d_r);

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl1_r  <= `TMI_CTRL1_RST;
         ctrl2_r  <= `TMI_CTRL2_RST;
         evt_en_r <= 5'h00;
      end else if (i_wr) begin
         case (i_addr)
            `TMI_ADDR_CTRL1:  ctrl1_r  <= i_wdata;
            `TMI_ADDR_CTRL2:  ctrl2_r  <= i_wdata;
            `TMI_ADDR_IRQ_EN: evt_en_r <= i_wdata[4:0];
            default: ;
         endcase
      end
   end

   assign sh_we = i_wr & ((i_addr == `TMI_ADDR_CMP2_SHADOW) |
                          (i_addr == (`TMI_ADDR_CMP2_SHADOW + 4'h1)));

   tmi_shadow_mem u_shadow (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_we       (sh_we),
      .i_sel      (~i_addr[0]),      // index 6 is the high byte
      .i_wdata    (i_wdata),
      .o_rdata_hi (sh_hi),
      .o_rdata_lo (sh_lo)
   );

   ////////////////////////////////////////////////////////////////////////
   // flag set terms, ordered as cap1 cmp1 ovf cap2 cmp2
   always @* begin
      flag_set = 5'h00;
      // pwm: capture one marks period end
      flag_set[4] = pwm_mode ? i_cmp2_match : (cap1_edge & ~ctrl2_r[`TMI_C2_SINGLE]);
      flag_set[3] = i_cmp1_match & ~pwm_mode & ~ctrl2_r[`TMI_C2_SINGLE];
      flag_set[2] = i_ovf_evt;
      // second flags held low in first instance
      flag_set[1] = i_cap2_evt & (FIRST_INSTANCE == 0);
      flag_set[0] = i_cmp2_match & ~pwm_mode & (FIRST_INSTANCE == 0);
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky flags and event status; set wins over clear
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_flag
         always @(posedge i_mclk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               flag_r[g]     <= 1'b0;
               evt_stat_r[g] <= 1'b0;
            end else begin
               // flag clear by external access sequence
               if (flag_set[g]) begin
                  flag_r[g] <= 1'b1;
               end else if (flag_clr[g]) begin
                  flag_r[g] <= 1'b0;
               end
               if (flag_set[g]) begin
                  evt_stat_r[g] <= 1'b1;
               end else if (i_wr && i_addr == `TMI_ADDR_IRQ_CLR && i_wdata[g]) begin
                  evt_stat_r[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign cap_gate = (flag_r[4] | flag_r[1]) & ctrl1_r[`TMI_C1_CAP_IE];
   assign cmp_gate = (flag_r[3] | flag_r[0]) & ctrl1_r[`TMI_C1_CMP_IE];
   assign ovf_gate = flag_r[2] & ctrl1_r[`TMI_C1_OVF_IE];
   // event status path, enabled bits
   assign evt_gate = |(evt_stat_r & evt_en_r);
   assign irq_req  = ~i_cpu_mask & (cap_gate | cmp_gate | ovf_gate | evt_gate);

   ////////////////////////////////////////////////////////////////////////
   // interrupt and wake outputs
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq  <= 1'b0;
         o_wake <= 1'b0;
      end else begin
         o_irq  <= irq_req;
         o_wake <= irq_req & i_in_wait;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer clock enable divider
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_r  <= 3'h0;
         o_tick <= 1'b0;
      end else begin
         div_r <= div_r + 3'h1;
         case (ctrl2_r[`TMI_C2_CLK_HI:`TMI_C2_CLK_LO])
            `TMI_CS_DIV4: o_tick <= (div_r[1:0] == 2'h3);
            `TMI_CS_DIV2: o_tick <= div_r[0];
            `TMI_CS_DIV8: o_tick <= (div_r == 3'h7);
            default:      o_tick <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare pin drive and capture trigger
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cmp_pin1    <= 1'b0;
         o_cmp_pin2    <= 1'b0;
         o_cmp_pin1_oe <= 1'b0;
         o_cmp_pin2_oe <= 1'b0;
         o_cap1_trig   <= 1'b0;
      end else begin
         o_cmp_pin1_oe <= ctrl2_r[`TMI_C2_PIN1_EN];
         o_cmp_pin2_oe <= ctrl2_r[`TMI_C2_PIN2_EN];
         o_cap1_trig   <= cap1_edge;
         if (ctrl2_r[`TMI_C2_PIN1_EN]) begin
            if (pulse_mode && i_cmp2_match) begin
               o_cmp_pin1 <= ctrl1_r[`TMI_C1_LVL2];
            end else if (ctrl1_r[`TMI_C1_FORCE1] || i_cmp1_match) begin
               o_cmp_pin1 <= ctrl1_r[`TMI_C1_LVL1];
            end
         end
         if (ctrl2_r[`TMI_C2_PIN2_EN]) begin
            if (ctrl1_r[`TMI_C1_FORCE2] ||
                (i_cmp2_match && !pulse_mode && FIRST_INSTANCE == 0)) begin
               o_cmp_pin2 <= ctrl1_r[`TMI_C1_LVL2];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; data one cycle after strobe
   always @* begin
      rdata_nxt = 8'h00;
      case (i_addr)
         `TMI_ADDR_CTRL1:    rdata_nxt = ctrl1_r;
         `TMI_ADDR_CTRL2:    rdata_nxt = ctrl2_r;
         `TMI_ADDR_STATUS: begin
            rdata_nxt[`TMI_ST_CAP1] = flag_r[4];
            rdata_nxt[`TMI_ST_CMP1] = flag_r[3];
            rdata_nxt[`TMI_ST_OVF]  = flag_r[2];
            rdata_nxt[`TMI_ST_CAP2] = flag_r[1];
            rdata_nxt[`TMI_ST_CMP2] = flag_r[0];
         end
         `TMI_ADDR_IRQ_STAT: rdata_nxt = {3'h0, evt_stat_r};
         `TMI_ADDR_IRQ_EN:   rdata_nxt = {3'h0, evt_en_r};
         `TMI_ADDR_CMP2_SHADOW: rdata_nxt = (FIRST_INSTANCE == 0) ? sh_hi : 8'h00;
         (`TMI_ADDR_CMP2_SHADOW + 4'h1): rdata_nxt = (FIRST_INSTANCE == 0) ? sh_lo : 8'h00;
         default:            rdata_nxt = 8'h00;
      endcase
   end

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= i_rd ? rdata_nxt : 8'h00;
      end
   end

endmodule

`default_nettype wire

// *** verification/tmi_cpu_model.sv ***
// Purpose: cpu side model on the register port
// Assumes: one cycle strobes, read data next cycle
// Notes:   released write data shows its inverse
`timescale 1ns/1ns
`default_nettype none
module tmi_cpu_model (
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_rdata,
   output var  logic [3:0] o_addr,
   output var  logic [7:0] o_wdata,
   output var  logic       o_wr,
   output var  logic       o_rd,
   output var  logic [4:0] o_clr
);
   ////////////////////////////////////////
   initial {o_addr, o_wdata, o_wr, o_rd, o_clr} = '0;
   // one strobe cycle, read data taken after it
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] v, output logic [7:0] q);
      @(posedge i_mclk);
      o_addr  <= a;
      o_wdata <= v;
      o_wr    <= w;
      o_rd    <= !w;
      @(posedge i_mclk);
      {o_wr, o_rd} <= 2'h0;
      o_wdata      <= ~v;
      #1 q = i_rdata;
   endtask
   task automatic clr(input logic [4:0] m);
      logic [7:0] s;
      xfer(1'b0, 4'h2, 8'h00, s);
      @(posedge i_mclk);
      o_clr <= m;
      @(posedge i_mclk);
      o_clr <= 5'h00;
   endtask
endmodule
`default_nettype wire

// *** verification/tmi_ctrl_asserts.sv ***
// Purpose: port assertions for the timer irq and control block
// Assumes: one clock, async active low reset
// Notes:   mirrors register writes to know the gating
`timescale 1ns/1ns
`default_nettype none
module tmi_ctrl_asserts (
   input wire logic       i_mclk,
   input wire logic       i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic       i_cpu_mask,
   input wire logic       i_cap1_pin,
   input wire logic       i_cmp1_match,
   input wire logic       i_cmp2_match,
   input wire logic       i_ovf_evt,
   input wire logic [7:0] o_rdata,
   input wire logic       o_irq,
   input wire logic       o_cap1_trig
);
   logic [7:0] c1_r, c2_r, en_r;
   ////////////////////////////////////////
   // mirror of control and enable writes
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         c1_r <= 8'h00;
         c2_r <= 8'h00;
         en_r <= 8'h00;
      end else if (i_wr) begin
         if (i_addr == 4'h0) c1_r <= i_wdata;
         if (i_addr == 4'h1) c2_r <= i_wdata;
         if (i_addr == 4'h5) en_r <= i_wdata;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // event taken, gate held open one more cycle
   sequence s_evt_on(ev, en);
      ev && en && !i_cpu_mask ##1 en && !i_cpu_mask;
   endsequence
   property p_mask; i_cpu_mask |=> !o_irq; endproperty
   a_mask: assert property (p_mask) else $error("irq while masked");
   property p_no_en; c1_r[7:5] == 3'h0 && en_r[4:0] == 5'h0 |=> !o_irq; endproperty
   a_no_en: assert property (p_no_en) else $error("irq with no enable");
   property p_ovf; s_evt_on(i_ovf_evt, c1_r[5]) |=> o_irq; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow irq missing");
   property p_cmp; s_evt_on(i_cmp1_match, c1_r[6] && c2_r[5:4] == 2'h0) |=> o_irq; endproperty
   a_cmp: assert property (p_cmp) else $error("compare irq missing");
   property p_cap; s_evt_on(i_cmp2_match, c1_r[7] && c2_r[4]) |=> o_irq; endproperty
   a_cap: assert property (p_cap) else $error("period end irq missing");
   property p_edge; (c1_r[1] ? $rose(i_cap1_pin) : $fell(i_cap1_pin)) |-> ##[1:5] o_cap1_trig; endproperty
   a_edge: assert property (p_edge) else $error("capture edge missed");
   property p_read; i_rd && i_addr == 4'h0 |=> o_rdata == $past(c1_r); endproperty
   a_read: assert property (p_read) else $error("control read wrong");
   property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
endmodule
`default_nettype wire

// *** verification/tmi_timer_ctrl_tb.sv ***
// Purpose: self checking bench for the timer irq and control block
// Assumes: 100 MHz clock, first timer instance
// Notes:   gating table first, then hand written cases
`timescale 1ns/1ns
`default_nettype none
module tmi_timer_ctrl_tb;
   logic        clk, rst_n, mask, wt, pin, wr, rd, irq, wake, trig, tick, p1, e1, p2, e2;
   logic [3:0]  addr, ev;
   logic [4:0]  clr;
   logic [7:0]  wdata, rdata, d, c1, c2, fl;
   int          n_fail, compares;
   // ctrl1, ctrl2, events, mask, expected irq
   logic [23:0] rows [10] = '{24'h200011, 24'h200012, 24'h000010, 24'h400041, 24'h401040,
                             24'h402040, 24'h801021, 24'h400020, 24'h800080, 24'h800040};
   ////////////////////////////////////////
   tmi_timer_ctrl u_tmi_timer_ctrl (.i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .i_cpu_mask(mask), .i_in_wait(wt), .i_cap1_pin(pin), .i_cap2_evt(ev[3]),
      .i_cmp1_match(ev[2]), .i_cmp2_match(ev[1]), .i_ovf_evt(ev[0]), .i_flag_clr_cap1(clr[4]),
      .i_flag_clr_cap2(clr[3]), .i_flag_clr_cmp1(clr[2]), .i_flag_clr_cmp2(clr[1]), .i_flag_clr_ovf(clr[0]),
      .o_rdata(rdata), .o_irq(irq), .o_wake(wake), .o_cap1_trig(trig), .o_tick(tick),
      .o_cmp_pin1(p1), .o_cmp_pin1_oe(e1), .o_cmp_pin2(p2), .o_cmp_pin2_oe(e2));
   tmi_cpu_model u_tmi_cpu_model (.i_mclk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .o_clr(clr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   task w(input logic [3:0] a, input logic [7:0] v);
      u_tmi_cpu_model.xfer(1'b1, a, v, d);
   endtask
   task rc(input logic [3:0] a, input logic [7:0] e, input string s);
      u_tmi_cpu_model.xfer(1'b0, a, 8'h00, d);
      chk(s, e, d);
   endtask
   task pulse(input logic [3:0] v, input logic m);
      @(posedge clk);
      ev   <= v;
      mask <= m;
      @(posedge clk);
      ev <= 4'h0;
   endtask
   task irq_chk(input logic e);
      repeat (4) @(posedge clk);
      #1 chk("irq", {7'h0, e}, {7'h0, irq});
   endtask
   // count trigger pulses after a pin change
   task edge_chk(input logic v, input logic [7:0] e);
      @(posedge clk);
      pin <= v;
      d = 8'h00;
      repeat (8) begin
         @(posedge clk);
         #1 d = d + {7'h0, trig};
      end
      chk("trig", e, d);
   endtask
   task pins_chk(input logic [7:0] e);
      repeat (3) @(posedge clk);
      #1 chk("pins", e, {4'h0, e1, p1, e2, p2});
   endtask
   // count timer enables over sixteen cycles
   task tick_chk(input logic [7:0] v, input logic [7:0] e);
      w(4'h1, v);
      d = 8'h00;
      repeat (16) begin
         @(posedge clk);
         #1 d = d + {7'h0, tick};
      end
      chk("tick", e, d);
   endtask
   task summarize;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      {rst_n, mask, wt, pin, ev} = '0;
      n_fail = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[k]) begin
         {c1, c2, fl} = rows[k];
         w(4'h0, c1);
         w(4'h1, c2);
         rc(4'h0, c1, "ctrl1");
         rc(4'h1, c2, "ctrl2");
         pulse(fl[7:4], fl[1]);
         irq_chk(fl[0]);
         u_tmi_cpu_model.clr(5'h1f);
         irq_chk(1'b0);
      end
      // capture edge, both polarities
      w(4'h0, 8'h02);
      edge_chk(1'b1, 8'h01);
      edge_chk(1'b0, 8'h00);
      w(4'h0, 8'h00);
      edge_chk(1'b1, 8'h00);
      edge_chk(1'b0, 8'h01);
      // forced pin levels
      w(4'h1, 8'hc0);
      w(4'h0, 8'h1d);
      pins_chk(8'h0f);
      w(4'h0, 8'h18);
      pins_chk(8'h0a);
      // pulse mode: level two on second match, level one on first
      w(4'h0, 8'h04);
      w(4'h1, 8'h90);
      pulse(4'h2, 1'b0);
      pins_chk(8'h0c);
      pulse(4'h4, 1'b0);
      pins_chk(8'h08);
      // timer enable rates
      tick_chk(8'h00, 8'h04);
      tick_chk(8'h04, 8'h08);
      tick_chk(8'h08, 8'h02);
      tick_chk(8'h0c, 8'h00);
      // event status path: raise, mask, wake, clear
      w(4'h0, 8'h00);
      w(4'h1, 8'h00);
      u_tmi_cpu_model.clr(5'h1f);
      w(4'h4, 8'h1f);
      w(4'h5, 8'h04);
      @(posedge clk) wt <= 1'b1;
      pulse(4'h1, 1'b0);
      irq_chk(1'b1);
      chk("wake", 8'h01, {7'h0, wake});
      rc(4'h3, 8'h04, "evst");
      @(posedge clk) mask <= 1'b1;
      irq_chk(1'b0);
      @(posedge clk) mask <= 1'b0;
      irq_chk(1'b1);
      @(posedge clk) wt <= 1'b0;
      irq_chk(1'b1);
      chk("wake", 8'h00, {7'h0, wake});
      w(4'h4, 8'h04);
      irq_chk(1'b0);
      rc(4'h3, 8'h00, "evst");
      // write-only and unmapped places
      w(4'h6, 8'ha5);
      rc(4'h6, 8'h00, "cmp2");
      w(4'hf, 8'hff);
      rc(4'hf, 8'h00, "unmapped");
      rc(4'h1, 8'h00, "ctrl2");
      // second reset in mid run
      w(4'h0, 8'hff);
      @(posedge clk) rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rc(4'h0, 8'h00, "ctrl1");
      rc(4'h1, 8'h00, "ctrl2");
      summarize;
   end
endmodule
bind tmi_timer_ctrl tmi_ctrl_asserts u_tmi_ctrl_asserts (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cpu_mask(i_cpu_mask),
   .i_cap1_pin(i_cap1_pin), .i_cmp1_match(i_cmp1_match), .i_cmp2_match(i_cmp2_match),
   .i_ovf_evt(i_ovf_evt), .o_rdata(o_rdata), .o_irq(o_irq), .o_cap1_trig(o_cap1_trig));
`default_nettype wire
